// ==== src/acd_alu.sv ====
// Combinational add and AND unit with flag generation
module acd_alu
    import acd_pkg::*;
#(
    parameter int W = DATA_W
) (
    // Operand and result bundle
    acd_alu_if.alu bus
);
    logic [W:0]        sum;
    logic [NIBBLE_W:0] halfSum;

    initial begin
        if (W < NIBBLE_W + 1) begin
            $error("acd_alu: width too small");
        end
    end

    always_comb begin
        sum = {1'b0, bus.accIn} + {1'b0, bus.operand};
        halfSum = {1'b0, bus.accIn[NIBBLE_W-1:0]} + {1'b0, bus.operand[NIBBLE_W-1:0]};
        case (bus.op)
            ACD_OP_ADD_MEM: bus.result = sum[W-1:0]; // RULE1
            ACD_OP_AND_ACC: bus.result = bus.accIn & bus.operand; // RULE3
            ACD_OP_AND_IMM: bus.result = bus.accIn & bus.operand; // RULE5
            ACD_OP_AND_MEM: bus.result = bus.accIn & bus.operand; // RULE6
            default:        bus.result = sum[W-1:0];
        endcase
    end

    // Flags from the sum, zero flag from the result
    assign bus.carryOut  = sum[W]; // RULE2
    assign bus.halfOut   = halfSum[NIBBLE_W]; // RULE2
    assign bus.signedOut = (bus.accIn[W-1] == bus.operand[W-1])
                         && (sum[W-1] != bus.accIn[W-1]); // RULE2
    assign bus.zeroOut   = (bus.result == '0); // RULE7
endmodule

// ==== src/acd_alu_if.sv ====
// Operand and result bundle between the datapath control and its arithmetic unit
interface acd_alu_if
    import acd_pkg::*;
#(
    parameter int W = DATA_W
);
    acd_op_t        op;
    logic [W-1:0]   accIn;
    logic [W-1:0]   operand;
    logic [W-1:0]   result;
    logic           carryOut;
    logic           halfOut;
    logic           signedOut;
    logic           zeroOut;

    modport ctrl (output op, accIn, operand, input result, carryOut, halfOut, signedOut, zeroOut);
    modport alu  (input op, accIn, operand, output result, carryOut, halfOut, signedOut, zeroOut);
endinterface

// ==== src/acd_datapath.sv ====
// Accumulator add and AND datapath top level
// Function
// RULE1 - An add-to-memory sums the accumulator and the memory byte and writes it back to memory.
// RULE2 - An add-to-memory updates the signed range, null, half byte and carry flags from the sum.
// RULE3 - A memory AND places accumulator AND memory byte into the accumulator only.
// RULE4 - A memory AND updates only the null flag, leaving the other flags as they were.
// RULE5 - An immediate AND places accumulator AND immediate byte into the accumulator and sets null.
// RULE6 - An AND-to-memory writes accumulator AND memory byte back into that memory location.
// RULE7 - All data is eight bits wide and null is set exactly when all result bits are zero.
module acd_datapath
    import acd_pkg::*;
#(
    parameter int DataWidth = DATA_W,
    parameter int AddrWidth = ADDR_W
) (
    // Clock, reset and enable
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    input  wire logic                 clkEn,
    // Operation request from the decoder
    input  wire logic                 opValid,
    input  wire acd_op_t              opCode,
    input  wire logic [AddrWidth-1:0] memAddr,
    input  wire logic [DataWidth-1:0] memOperand,
    input  wire logic [DataWidth-1:0] immData,
    // Direct accumulator load
    input  wire logic                 accLoad,
    input  wire logic [DataWidth-1:0] accLoadData,
    // Accumulator and flags
    output logic [DataWidth-1:0]      accValue,
    output logic                      signedRangeFlag,
    output logic                      nullFlag,
    output logic                      halfByteFlag,
    output logic                      carryFlag,
    // Data memory write port
    output logic                      memWrEn,
    output logic [AddrWidth-1:0]      memWrAddr,
    output logic [DataWidth-1:0]      memWrData,
    // Completion
    output logic                      opDone
);
    logic       issue;
    logic       writesMem;
    logic       writesAcc;
    logic       fullFlags;

    acd_alu_if #(.W(DataWidth)) aluBus ();

    acd_alu #(.W(DataWidth)) u_alu (
        .bus (aluBus)
    );

    initial begin
        if (DataWidth != DATA_W) begin
            $error("acd_datapath: data width must be eight");
        end
        if (AddrWidth < 1) begin
            $error("acd_datapath: address width must be positive");
        end
    end

    assign aluBus.op      = opCode;
    assign aluBus.accIn   = accValue;
    assign aluBus.operand = (opCode == ACD_OP_AND_IMM) ? immData : memOperand;

    assign issue     = clkEn && opValid;
    assign writesMem = (opCode == ACD_OP_ADD_MEM) || (opCode == ACD_OP_AND_MEM);
    assign writesAcc = (opCode == ACD_OP_AND_ACC) || (opCode == ACD_OP_AND_IMM);
    assign fullFlags = (opCode == ACD_OP_ADD_MEM);

    // Accumulator
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            accValue <= ACC_RESET;
        end else if (clkEn) begin
            if (opValid && writesAcc) begin
                accValue <= aluBus.result; // RULE3 RULE5
            end else if (opValid) begin
                accValue <= accValue; // RULE1
            end else if (accLoad) begin
                accValue <= accLoadData;
            end
        end
    end

    // Status flags
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            signedRangeFlag <= FLAG_RESET;
            nullFlag        <= FLAG_RESET;
            halfByteFlag    <= FLAG_RESET;
            carryFlag       <= FLAG_RESET;
        end else if (issue) begin
            nullFlag <= aluBus.zeroOut; // RULE4 RULE5 RULE7
            if (fullFlags) begin
                signedRangeFlag <= aluBus.signedOut; // RULE2
                halfByteFlag    <= aluBus.halfOut; // RULE2
                carryFlag       <= aluBus.carryOut; // RULE2
            end
        end
    end

    // Memory write port
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            memWrEn   <= FLAG_RESET;
            memWrAddr <= ADDR_RESET;
            memWrData <= DATA_RESET;
        end else if (clkEn) begin
            memWrEn <= opValid && writesMem; // RULE1 RULE6
            if (opValid && writesMem) begin
                memWrAddr <= memAddr;
                memWrData <= aluBus.result; // RULE1 RULE6
            end
        end
    end

    // Completion pulse
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            opDone <= FLAG_RESET;
        end else if (clkEn) begin
            opDone <= opValid;
        end
    end

    // Reference values for checking
    logic [DataWidth:0]   chkSum;
    logic [DataWidth-1:0] chkSumLo;
    logic                 chkCarry;
    logic [NIBBLE_W:0]    chkHalfSum;
    logic                 chkHalf;
    logic [DataWidth-1:0] chkAndMem;
    logic [DataWidth-1:0] chkAndImm;
    logic                 chkSigned;

    assign chkSum     = {1'b0, accValue} + {1'b0, memOperand};
    assign chkSumLo   = chkSum[DataWidth-1:0];
    assign chkCarry   = chkSum[DataWidth];
    assign chkHalfSum = {1'b0, accValue[NIBBLE_W-1:0]} + {1'b0, memOperand[NIBBLE_W-1:0]};
    assign chkHalf    = chkHalfSum[NIBBLE_W];
    assign chkAndMem  = accValue & memOperand;
    assign chkAndImm  = accValue & immData;
    assign chkSigned  = (accValue[DataWidth-1] == memOperand[DataWidth-1])
                      && (chkSumLo[DataWidth-1] != accValue[DataWidth-1]);

    sequence addIssued;
        opValid && clkEn && (opCode == ACD_OP_ADD_MEM);
    endsequence
    sequence andAccIssued;
        opValid && clkEn && (opCode == ACD_OP_AND_ACC);
    endsequence
    sequence andImmIssued;
        opValid && clkEn && (opCode == ACD_OP_AND_IMM);
    endsequence
    sequence andMemIssued;
        opValid && clkEn && (opCode == ACD_OP_AND_MEM);
    endsequence
    sequence loadIssued;
        clkEn && accLoad && !opValid;
    endsequence

    addWrite_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE1
        addIssued |=> memWrEn && (memWrData == $past(chkSumLo)) && $stable(accValue)
                      && (memWrAddr == $past(memAddr)))
        else $error("add result not written to memory");

    addFlags_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE2
        addIssued |=> (carryFlag == $past(chkCarry)) && (halfByteFlag == $past(chkHalf))
                      && (nullFlag == (memWrData == '0)))
        else $error("add flags wrong");

    andAccLoad_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE3
        andAccIssued |=> (accValue == $past(chkAndMem)) && !memWrEn)
        else $error("memory and result wrong");

    andFlagsKept_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE4
        andAccIssued |=> $stable(carryFlag) && $stable(halfByteFlag)
                         && $stable(signedRangeFlag) && (nullFlag == (accValue == '0)))
        else $error("memory and disturbed flags");

    andImmLoad_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
        andImmIssued |=> (accValue == $past(chkAndImm)) && (nullFlag == (accValue == '0)))
        else $error("immediate and result wrong");

    andToMem_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE6
        andMemIssued |=> memWrEn && (memWrData == $past(chkAndMem)) && $stable(accValue))
        else $error("and to memory wrong");

    nullExact_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE7
        andMemIssued |=> nullFlag == (memWrData == '0))
        else $error("null flag mismatch");

    freezeHold_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !clkEn |=> $stable(accValue) && $stable(memWrEn) && $stable(opDone))
        else $error("state moved while disabled");

    addSigned_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE2
        addIssued |=> signedRangeFlag == $past(chkSigned))
        else $error("add signed range flag wrong");

    immFlagsKept_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
        andImmIssued |=> $stable(carryFlag) && $stable(halfByteFlag)
                         && $stable(signedRangeFlag) && !memWrEn)
        else $error("immediate and disturbed flags or memory");

    andMemKept_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE6
        andMemIssued |=> $stable(carryFlag) && $stable(halfByteFlag)
                         && $stable(signedRangeFlag) && (memWrAddr == $past(memAddr)))
        else $error("and to memory disturbed flags or address");

    loadAcc_a: assert property (@(posedge mclk) disable iff (!reset_n)
        loadIssued |=> accValue == $past(accLoadData))
        else $error("accumulator load wrong");

    doneFollow_a: assert property (@(posedge mclk) disable iff (!reset_n)
        opValid && clkEn |=> opDone)
        else $error("completion pulse missing");

    idleQuiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
        clkEn && !opValid |=> !memWrEn && !opDone)
        else $error("write or completion without request");

    memHold_a: assert property (@(posedge mclk) disable iff (!reset_n)
        clkEn && !(opValid && writesMem) |=> $stable(memWrAddr) && $stable(memWrData))
        else $error("write port moved without a write");
endmodule

// ==== src/acd_pkg.sv ====
// Shared widths, operation codes and reset values for the accumulator datapath
package acd_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int NIBBLE_W = 4;

    // Operation codes, Gray ordered
    typedef enum logic [1:0] {
        ACD_OP_ADD_MEM = 2'h0,
        ACD_OP_AND_ACC = 2'h1,
        ACD_OP_AND_IMM = 2'h3,
        ACD_OP_AND_MEM = 2'h2
    } acd_op_t;

    localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
    localparam logic              FLAG_RESET = 1'h0;
endpackage

// ==== testbench/accumulator_add_and_datapath_tb.sv ====
// Random self-checking bench comparing the datapath with a reference model
module accumulator_add_and_datapath_tb
    import acd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic              mclk = 1'b0;
    logic              reset_n = 1'b0;
    logic              clkEn = 1'b0;
    logic              opValid = 1'b0;
    logic              accLoad = 1'b0;
    acd_op_t           opCode = ACD_OP_ADD_MEM;
    logic [ADDR_W-1:0] memAddr = 7'h00;
    logic [DATA_W-1:0] immData = 8'h00;
    logic [DATA_W-1:0] accLoadData = 8'h00;
    logic [DATA_W-1:0] memOperand, accValue, memWrData;
    logic [ADDR_W-1:0] memWrAddr;
    logic              signedRangeFlag, nullFlag, halfByteFlag, carryFlag, memWrEn, opDone;
    integer            seed = 32'hE2811927;
    int                errors = 0;
    int                checkCount = 0;
    int                mem [128];
    int                acc, sr, nl, hb, cy, wr, wa, wd, dn, a, m, s, r;

    acd_datapath DUT (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .opValid(opValid),
        .opCode(opCode), .memAddr(memAddr), .memOperand(memOperand), .immData(immData),
        .accLoad(accLoad), .accLoadData(accLoadData), .accValue(accValue),
        .signedRangeFlag(signedRangeFlag), .nullFlag(nullFlag), .halfByteFlag(halfByteFlag),
        .carryFlag(carryFlag), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
        .memWrData(memWrData), .opDone(opDone));
    acd_mem_model memU (.mclk(mclk), .rdAddr(memAddr), .rdData(memOperand),
        .wrEn(memWrEn), .wrAddr(memWrAddr), .wrData(memWrData));

    always #50 mclk = ~mclk;

    task automatic chkByte(string name, logic [7:0] exp, logic [7:0] got);
        checkCount++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chkFlag(string name, logic exp, logic got);
        checkCount++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic test_done;
        if (errors == 0 && checkCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Reference update for what the design sampled at this edge
    task automatic step;
        if (clkEn) begin
            wr = 0;
            dn = opValid;
            a = acc;
            m = mem[memAddr];
            if (opValid) begin
                case (opCode)
                    ACD_OP_ADD_MEM: begin
                        s = a + m;
                        cy = s[8];
                        hb = (a % 16 + m % 16) > 15;
                        sr = (a[7] == m[7]) && (s[7] != a[7]);
                        r = s & 255;
                        wr = 1;
                    end
                    ACD_OP_AND_ACC: r = a & m;
                    ACD_OP_AND_IMM: r = a & immData;
                    default: r = a & m;
                endcase
                if (opCode == ACD_OP_AND_MEM) wr = 1;
                if (wr == 0) acc = r;
                nl = (r == 0);
                if (wr) mem[memAddr] = r;
                wa = memAddr;
                wd = r;
            end else if (accLoad) begin
                acc = accLoadData;
            end
        end
    endtask

    task automatic compare;
        @(negedge mclk);
        chkByte("accValue", 8'(acc), accValue);
        chkFlag("signedRangeFlag", sr[0], signedRangeFlag);
        chkFlag("halfByteFlag", hb[0], halfByteFlag);
        chkFlag("carryFlag", cy[0], carryFlag);
        chkFlag("nullFlag", nl[0], nullFlag);
        chkFlag("memWrEn", wr[0], memWrEn);
        chkFlag("opDone", dn[0], opDone);
        if (wr == 1) begin
            chkByte("memWrAddr", 8'(wa), 8'(memWrAddr));
            chkByte("memWrData", 8'(wd), memWrData);
        end
    endtask

    task automatic randCycle;
        @(posedge mclk);
        step;
        clkEn <= ($random(seed) & 7) != 0;
        opValid <= 1'($random(seed));
        opCode <= acd_op_t'($random(seed) & 3);
        memAddr <= 7'($random(seed) & 7);
        immData <= 8'($random(seed));
        accLoad <= 1'($random(seed));
        accLoadData <= 8'($random(seed));
        compare;
    endtask

    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = $random(seed) & 255;
            memU.mem[i] = 8'(mem[i]);
        end
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        compare;
        repeat (1000) randCycle;
        // Let a pending write land, then reset in mid-run
        @(posedge mclk);
        step;
        clkEn <= 1'b1;
        opValid <= 1'b0;
        accLoad <= 1'b0;
        compare;
        @(posedge mclk);
        step;
        reset_n <= 1'b0;
        acc = 0;
        sr = 0;
        nl = 0;
        hb = 0;
        cy = 0;
        wr = 0;
        dn = 0;
        compare;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        compare;
        repeat (1000) randCycle;
        test_done;
    end

    initial begin
        #250000;
        errors++;
        test_done;
    end
endmodule

// ==== testbench/acd_mem_model.sv ====
// Data memory model that feeds the operand byte and takes the write-back
module acd_mem_model
    import acd_pkg::*;
(
    // Clock
    input  wire logic              mclk,
    // Read side
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic [DATA_W-1:0]      rdData,
    // Write side
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] mem [128];
    // Pending write is forwarded so a back-to-back operation sees fresh data
    assign rdData = (wrEn && wrAddr == rdAddr) ? wrData : mem[rdAddr];
    always @(posedge mclk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end
endmodule
